/* File: core/dpl_map.svh */
`ifndef DPL_MAP_SVH
`define DPL_MAP_SVH

// Register byte offsets
`define DPL_OFF_CTRL 8'h00
`define DPL_OFF_REF_DIV 8'h04
`define DPL_OFF_FB_DIV 8'h08
`define DPL_OFF_GAIN 8'h0C
`define DPL_OFF_STATUS 8'h10
`define DPL_OFF_PHASE 8'h14
`define DPL_OFF_TUNE 8'h18

// Control register fields
`define DPL_CTRL_REF_FALL 0
`define DPL_CTRL_REF_HALF 1
`define DPL_CTRL_FB_FALL 2
`define DPL_CTRL_FB_HALF 3
`define DPL_CTRL_REF_SEL 4
`define DPL_CTRL_APPLY 5
`define DPL_CTRL_EXP_LSB 8

// Gain register fields, four bits each
`define DPL_GAIN_KP_LSB 0
`define DPL_GAIN_KI_LSB 4
`define DPL_GAIN_POLE_LSB 8

// Status register fields
`define DPL_STAT_COARSE 0
`define DPL_STAT_PENDING 1
`define DPL_STAT_PFD_LSB 4
`define DPL_STAT_NEW 8

// Reset values
`define DPL_RST_FLAGS 5'h00
`define DPL_RST_EXP 5'h05
`define DPL_RST_DIV 16'h0000
`define DPL_RST_GAIN 12'h284

// Loop rate exponent limits
`define DPL_EXP_MIN 5'h05
`define DPL_EXP_MAX 5'h10

// Fine detector range and coarse resolution, as bit counts (log2 of clock cycles)
`define DPL_FINE_W 8
`define DPL_COARSE_SHIFT 2

`endif

/* File: core/dpl_pkg.sv */
package dpl_pkg;

  // Three-state comparator states
  typedef enum logic [2:0] {
    DPL_PFD_IDLE = 3'b001,
    DPL_PFD_LEAD = 3'b010,
    DPL_PFD_LAG = 3'b100
  } dpl_pfd_t;

endpackage

/* File: core/dpl_divider.sv */
`timescale 1ns/100ps
`include "dpl_map.svh"

module dpl_divider #(
  parameter int RATIO_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Synchronised input level
  input wire logic sig_sync,
  // Settings
  input wire logic falling,
  input wire logic halve,
  input wire logic [RATIO_W-1:0] ratio,
  input wire logic restart,
  // Divided output
  output logic div_tick
);

  typedef struct packed {
    logic prev;
    logic [RATIO_W-1:0] cnt;
    logic halv;
    logic tick;
  } dpl_div_st_t;

  dpl_div_st_t st_reg;
  dpl_div_st_t st_next;
  logic edge_seen;

  if (RATIO_W < 2 || RATIO_W > 24) begin : g_chk
    $error("dpl_divider: RATIO_W out of range");
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.prev = sig_sync;
    st_next.tick = 1'b0;
    edge_seen = falling ? (st_reg.prev & ~sig_sync)
                        : (~st_reg.prev & sig_sync);
    if (restart) begin
      st_next.cnt = '0;
      st_next.halv = 1'b0;
    end else if (edge_seen) begin
      if (st_reg.cnt == ratio) begin
        st_next.cnt = '0;
        st_next.halv = halve ? ~st_reg.halv : 1'b0;
        st_next.tick = ~halve | st_reg.halv;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign div_tick = st_reg.tick;

endmodule // dpl_divider

/* File: core/dpl_core.sv */
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "dpl_map.svh"

module dpl_core #(
  parameter int ADDR_W = 8,
  parameter int RATIO_W = 16,
  parameter int CNT_W = 20,
  parameter int LF_W = 40,
  parameter int CIC_W = 64,
  parameter int TUNE_W = 32
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pins
  input wire logic reference_input_first,
  input wire logic reference_input_second,
  input wire logic feedback_clock_input,
  // Synthesizer tuning
  output logic [TUNE_W-1:0] tuning_word,
  output logic loop_tick
);

  localparam int PERR_W = CNT_W + 1;

  typedef struct packed {
    logic [1:0] ra_sync;
    logic [1:0] rb_sync;
    logic [1:0] fb_sync;
    logic [RATIO_W-1:0] sh_ref_div;
    logic [RATIO_W-1:0] sh_fb_div;
    logic [RATIO_W-1:0] act_ref_div;
    logic [RATIO_W-1:0] act_fb_div;
    logic [4:0] sh_flags;
    logic [4:0] act_flags;
    logic [4:0] sh_exp;
    logic [4:0] act_exp;
    logic [11:0] gain;
    logic restart;
    dpl_pkg::dpl_pfd_t phase_frequency_comparator;
    logic [CNT_W-1:0] pfd_cnt;
    logic signed [PERR_W-1:0] perr;
    logic perr_new;
    logic coarse_used;
    logic [16:0] rate_cnt;
    logic loop_tick;
    logic signed [LF_W-1:0] lf_integ;
    logic signed [LF_W-1:0] lf_lp;
    logic signed [LF_W+1:0] c1_d;
    logic signed [LF_W+1:0] c2_d;
    logic signed [LF_W+1:0] comb;
    logic cic_go;
    logic signed [CIC_W-1:0] i1;
    logic signed [CIC_W-1:0] i2;
    logic [TUNE_W-1:0] tune;
    logic [31:0] prdata;
  } dpl_core_st_t;

  dpl_core_st_t st_reg;
  dpl_core_st_t st_next;
  logic ref_lvl;
  logic ref_tick;
  logic fb_tick;

  if (RATIO_W != 16 || CNT_W <= `DPL_FINE_W || LF_W < PERR_W + 16
      || CIC_W < LF_W + 19 || TUNE_W > CIC_W || ADDR_W < 5
      || ADDR_W > 32) begin : g_chk
    $error("dpl_core: parameter set not supported");
  end

  //////////////////////////////////////////////////////////////////////////
  // Only the second stage of each pin synchroniser is read here
  assign ref_lvl = st_reg.act_flags[`DPL_CTRL_REF_SEL] ? st_reg.rb_sync[1]
                                                      : st_reg.ra_sync[1];

  dpl_divider #(
    .RATIO_W(RATIO_W)
  ) u_ref_div (
    .pclk(pclk),
    .presetn(presetn),
    .sig_sync(ref_lvl),
    .falling(st_reg.act_flags[`DPL_CTRL_REF_FALL]),
    .halve(st_reg.act_flags[`DPL_CTRL_REF_HALF]),
    .ratio(st_reg.act_ref_div),
    .restart(st_reg.restart),
    .div_tick(ref_tick)
  );

  dpl_divider #(
    .RATIO_W(RATIO_W)
  ) u_fb_div (
    .pclk(pclk),
    .presetn(presetn),
    .sig_sync(st_reg.fb_sync[1]),
    .falling(st_reg.act_flags[`DPL_CTRL_FB_FALL]),
    .halve(st_reg.act_flags[`DPL_CTRL_FB_HALF]),
    .ratio(st_reg.act_fb_div),
    .restart(st_reg.restart),
    .div_tick(fb_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic emit;
    logic fine_ovf;
    logic [CNT_W-1:0] mag;
    logic signed [PERR_W-1:0] meas;
    logic tick;
    logic signed [LF_W-1:0] err;
    logic signed [LF_W-1:0] raw;
    logic signed [LF_W+1:0] c1;
    logic signed [LF_W+1:0] c2;
    logic signed [CIC_W-1:0] cin;
    logic wr;
    logic [ADDR_W-1:0] a;
    logic [4:0] wexp;
    emit = 1'b0;
    fine_ovf = 1'b0;
    mag = '0;
    meas = '0;
    tick = 1'b0;
    err = '0;
    raw = '0;
    c1 = '0;
    c2 = '0;
    cin = '0;
    wr = psel & penable & pwrite;
    a = paddr;
    wexp = pwdata[`DPL_CTRL_EXP_LSB +: 5];
    st_next = st_reg;
    st_next.ra_sync = {st_reg.ra_sync[0], reference_input_first};
    st_next.rb_sync = {st_reg.rb_sync[0], reference_input_second};
    st_next.fb_sync = {st_reg.fb_sync[0], feedback_clock_input};
    st_next.restart = 1'b0;

    // Three-state comparator; pulse width counted in clock cycles
    // Concurrent pulse measurement
    case (st_reg.phase_frequency_comparator)
      dpl_pkg::DPL_PFD_IDLE: begin
        if (ref_tick && fb_tick) begin
          emit = 1'b1;
        end else if (ref_tick) begin
          st_next.phase_frequency_comparator = dpl_pkg::DPL_PFD_LEAD;
          st_next.pfd_cnt = CNT_W'(1);
        end else if (fb_tick) begin
          st_next.phase_frequency_comparator = dpl_pkg::DPL_PFD_LAG;
          st_next.pfd_cnt = CNT_W'(1);
        end
      end
      dpl_pkg::DPL_PFD_LEAD, dpl_pkg::DPL_PFD_LAG: begin
        if ((st_reg.phase_frequency_comparator == dpl_pkg::DPL_PFD_LEAD) ? fb_tick : ref_tick) begin
          emit = 1'b1;
          st_next.phase_frequency_comparator = dpl_pkg::DPL_PFD_IDLE;
        end else if (~&st_reg.pfd_cnt) begin
          st_next.pfd_cnt = st_reg.pfd_cnt + 1'b1;
        end
      end
      default: begin
        st_next.phase_frequency_comparator = dpl_pkg::DPL_PFD_IDLE;
      end
    endcase

    // Fine range is narrow but exact; coarse spans the full count
    // Fine unless out of range
    fine_ovf = (st_reg.phase_frequency_comparator != dpl_pkg::DPL_PFD_IDLE)
               & (|st_reg.pfd_cnt[CNT_W-1:`DPL_FINE_W]);
    mag = fine_ovf ? {st_reg.pfd_cnt[CNT_W-1:`DPL_COARSE_SHIFT],
                      `DPL_COARSE_SHIFT'(0)}
                   : st_reg.pfd_cnt;
    if (st_reg.phase_frequency_comparator == dpl_pkg::DPL_PFD_IDLE) begin
      meas = '0;
    end else if (st_reg.phase_frequency_comparator == dpl_pkg::DPL_PFD_LEAD) begin
      meas = $signed({1'b0, mag});
    end else begin
      meas = -$signed({1'b0, mag});
    end

    if (st_reg.rate_cnt == (17'h0_0001 << st_reg.act_exp) - 17'h0_0001) begin
      tick = 1'b1;
      st_next.rate_cnt = '0;
    end else begin
      st_next.rate_cnt = st_reg.rate_cnt + 17'h0_0001;
    end
    st_next.loop_tick = tick;

    if (tick) begin
      err = st_reg.perr_new ? LF_W'(st_reg.perr) : '0;
      st_next.perr_new = 1'b0;
    end
    if (emit) begin
      st_next.perr = meas;
      st_next.coarse_used = fine_ovf;
      st_next.perr_new = 1'b1;
    end

    // Proportional-integral path with one pole behind it
    // Second-order loop filter
    if (tick) begin
      st_next.lf_integ = st_reg.lf_integ
                         + (err <<< st_reg.gain[`DPL_GAIN_KI_LSB +: 4]);
      raw = st_next.lf_integ + (err <<< st_reg.gain[`DPL_GAIN_KP_LSB +: 4]);
      st_next.lf_lp = st_reg.lf_lp + ((raw - st_reg.lf_lp)
                      >>> st_reg.gain[`DPL_GAIN_POLE_LSB +: 4]);
    end

    // Two combs at loop rate, two integrators at sample rate
    // Comb-integrator interpolation
    st_next.cic_go = st_reg.loop_tick;
    if (st_reg.loop_tick) begin
      c1 = (LF_W+2)'(st_reg.lf_lp) - st_reg.c1_d;
      c2 = c1 - st_reg.c2_d;
      st_next.c1_d = (LF_W+2)'(st_reg.lf_lp);
      st_next.c2_d = c1;
      st_next.comb = c2;
    end
    cin = st_reg.cic_go ? CIC_W'(st_reg.comb) : '0;
    st_next.i1 = st_reg.i1 + cin;
    st_next.i2 = st_reg.i2 + st_reg.i1;
    // Zero stuffing leaves a gain of 2**exp, removed here
    st_next.tune = TUNE_W'(st_reg.i2 >>> st_reg.act_exp);

    // APB read data is captured in the setup cycle
    if (psel && !penable) begin
      st_next.prdata = 32'h0000_0000;
      case (a)
        ADDR_W'(`DPL_OFF_CTRL): begin
          st_next.prdata[4:0] = st_reg.sh_flags;
          st_next.prdata[`DPL_CTRL_EXP_LSB +: 5] = st_reg.sh_exp;
        end
        ADDR_W'(`DPL_OFF_REF_DIV):
          st_next.prdata[RATIO_W-1:0] = st_reg.sh_ref_div;
        ADDR_W'(`DPL_OFF_FB_DIV):
          st_next.prdata[RATIO_W-1:0] = st_reg.sh_fb_div;
        ADDR_W'(`DPL_OFF_GAIN): st_next.prdata[11:0] = st_reg.gain;
        ADDR_W'(`DPL_OFF_STATUS): begin
          st_next.prdata[`DPL_STAT_COARSE] = st_reg.coarse_used;
          st_next.prdata[`DPL_STAT_PENDING] =
            (st_reg.sh_flags != st_reg.act_flags)
            || (st_reg.sh_exp != st_reg.act_exp)
            || (st_reg.sh_ref_div != st_reg.act_ref_div)
            || (st_reg.sh_fb_div != st_reg.act_fb_div);
          st_next.prdata[`DPL_STAT_PFD_LSB +: 3] = st_reg.phase_frequency_comparator;
          st_next.prdata[`DPL_STAT_NEW] = st_reg.perr_new;
        end
        ADDR_W'(`DPL_OFF_PHASE): st_next.prdata = 32'(st_reg.perr);
        ADDR_W'(`DPL_OFF_TUNE): st_next.prdata = 32'(st_reg.tune);
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end

    // Control and divider writes land in shadow settings until an apply; gain writes take effect at once
    if (wr) begin
      case (a)
        ADDR_W'(`DPL_OFF_CTRL): begin
          st_next.sh_flags = pwdata[4:0];
          // Out-of-range exponents are clamped to the legal span
          // Exponent limits
          if (wexp < `DPL_EXP_MIN) begin
            st_next.sh_exp = `DPL_EXP_MIN;
          end else if (wexp > `DPL_EXP_MAX) begin
            st_next.sh_exp = `DPL_EXP_MAX;
          end else begin
            st_next.sh_exp = wexp;
          end
        end
        ADDR_W'(`DPL_OFF_REF_DIV): st_next.sh_ref_div = pwdata[RATIO_W-1:0];
        ADDR_W'(`DPL_OFF_FB_DIV): st_next.sh_fb_div = pwdata[RATIO_W-1:0];
        ADDR_W'(`DPL_OFF_GAIN): st_next.gain = pwdata[11:0];
        default: st_next.gain = st_reg.gain;
      endcase
    end

    // Apply copies every shadow at once and restarts all counters
    // Apply with clean restart
    if (wr && a == ADDR_W'(`DPL_OFF_CTRL) && pwdata[`DPL_CTRL_APPLY]) begin
      st_next.act_flags = st_next.sh_flags;
      st_next.act_exp = st_next.sh_exp;
      st_next.act_ref_div = st_next.sh_ref_div;
      st_next.act_fb_div = st_next.sh_fb_div;
      st_next.restart = 1'b1;
    end
    if (st_reg.restart) begin
      st_next.phase_frequency_comparator = dpl_pkg::DPL_PFD_IDLE;
      st_next.pfd_cnt = '0;
      st_next.perr_new = 1'b0;
      st_next.rate_cnt = '0;
      st_next.loop_tick = 1'b0;
      st_next.cic_go = 1'b0;
      st_next.c1_d = '0;
      st_next.c2_d = '0;
      st_next.i1 = '0;
      st_next.i2 = '0;
      st_next.lf_integ = '0;
      st_next.lf_lp = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.phase_frequency_comparator <= dpl_pkg::DPL_PFD_IDLE;
      st_reg.sh_flags <= `DPL_RST_FLAGS;
      st_reg.act_flags <= `DPL_RST_FLAGS;
      st_reg.sh_exp <= `DPL_RST_EXP;
      st_reg.act_exp <= `DPL_RST_EXP;
      st_reg.sh_ref_div <= `DPL_RST_DIV;
      st_reg.act_ref_div <= `DPL_RST_DIV;
      st_reg.sh_fb_div <= `DPL_RST_DIV;
      st_reg.act_fb_div <= `DPL_RST_DIV;
      st_reg.gain <= `DPL_RST_GAIN;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable
                   & (paddr != ADDR_W'(`DPL_OFF_CTRL))
                   & (paddr != ADDR_W'(`DPL_OFF_REF_DIV))
                   & (paddr != ADDR_W'(`DPL_OFF_FB_DIV))
                   & (paddr != ADDR_W'(`DPL_OFF_GAIN))
                   & (paddr != ADDR_W'(`DPL_OFF_STATUS))
                   & (paddr != ADDR_W'(`DPL_OFF_PHASE))
                   & (paddr != ADDR_W'(`DPL_OFF_TUNE));
  assign prdata = st_reg.prdata;
  assign tuning_word = st_reg.tune;
  assign loop_tick = st_reg.loop_tick;

endmodule // dpl_core

/* File: tb/dpl_core_properties.sv */
`timescale 1ns/100ps
`include "dpl_map.svh"

module dpl_core_properties #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Loop rate
  input wire logic loop_tick
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [5:0] gap_reg;
  logic rd;
  assign rd = psel && penable && !pwrite;

  // Starts saturated: the first gap after reset is not bounded here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 6'h3F;
    end else if (loop_tick) begin
      gap_reg <= 6'h00;
    end else if (gap_reg != 6'h3F) begin
      gap_reg <= gap_reg + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  unmapped_err_a: assert property (psel && penable && paddr >= 8'h1C
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && paddr < 8'h1C
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved outside setup");
  tick_pulse_a: assert property (loop_tick |=> !loop_tick)
    else $error("loop tick longer than one cycle");
  tick_gap_a: assert property (loop_tick |-> gap_reg >= 6'd31)
    else $error("loop ticks closer than 32 cycles");
  apply_clear_a: assert property (
    rd && paddr == `DPL_OFF_CTRL |-> !prdata[`DPL_CTRL_APPLY])
    else $error("apply bit reads back set");
  exp_range_a: assert property (
    rd && paddr == `DPL_OFF_CTRL |-> prdata[12:8] inside {[5:16]})
    else $error("loop exponent out of range");
  div_width_a: assert property (
    rd && (paddr == `DPL_OFF_REF_DIV || paddr == `DPL_OFF_FB_DIV)
    |-> prdata[31:16] == 16'h0000)
    else $error("divider value wider than 16 bits");

  tick_c: cover property (loop_tick);
  unmapped_c: cover property (pslverr);
  ctrl_read_c: cover property (rd && paddr == `DPL_OFF_CTRL);
endmodule // dpl_core_properties

bind dpl_core dpl_core_properties #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .loop_tick(loop_tick)
);

/* File: tb/dpl_clk_src.sv */
`timescale 1ns/100ps

module dpl_clk_src (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command
  input wire logic req,
  input wire logic [1:0] line,
  input wire logic [7:0] toggles,
  output logic busy,
  // Pins: first reference, second reference, feedback
  output logic [2:0] pins
);
  logic [7:0] left;
  logic [1:0] ph;
  logic [1:0] sel;
  assign busy = left != 8'h00;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= 3'h0;
      left <= 8'h00;
      ph <= 2'h0;
      sel <= 2'h0;
    end else if (req) begin
      pins <= 3'h0;
      left <= toggles;
      sel <= line;
      ph <= 2'h0;
    end else if (busy) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        pins[sel] <= !pins[sel];
        left <= left - 8'h01;
      end
    end
  end
endmodule // dpl_clk_src

/* File: tb/tb.sv */
`timescale 1ns/100ps
`include "dpl_map.svh"

module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdata, tuning_word;
  logic pready, pslverr, loop_tick, busy, rerr;
  logic req = 1'b0;
  logic [1:0] line = 2'h0;
  logic [7:0] toggles = 8'h00;
  logic [2:0] pins;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] dv;
    logic [1:0] ln;
    logic [3:0] nt;
    logic [2:0] st;
  } dpl_row_t;
  dpl_row_t rows [15] = '{
    '{8'h00, 16'h0000, 2'h0, 4'h1, 3'h2}, '{8'h01, 16'h0000, 2'h0, 4'h1, 3'h1},
    '{8'h01, 16'h0000, 2'h0, 4'h2, 3'h2}, '{8'h00, 16'h0002, 2'h0, 4'h3, 3'h1},
    '{8'h00, 16'h0002, 2'h0, 4'h5, 3'h2}, '{8'h02, 16'h0000, 2'h0, 4'h1, 3'h1},
    '{8'h02, 16'h0000, 2'h0, 4'h3, 3'h2}, '{8'h00, 16'h0000, 2'h2, 4'h1, 3'h4},
    '{8'h04, 16'h0000, 2'h2, 4'h1, 3'h1}, '{8'h04, 16'h0000, 2'h2, 4'h2, 3'h4},
    '{8'h00, 16'h0001, 2'h2, 4'h1, 3'h1}, '{8'h00, 16'h0001, 2'h2, 4'h3, 3'h4},
    '{8'h08, 16'h0000, 2'h2, 4'h3, 3'h4}, '{8'h10, 16'h0000, 2'h1, 4'h1, 3'h2},
    '{8'h00, 16'h0000, 2'h1, 4'h1, 3'h1}};

  always #2.5 pclk = ~pclk;

  dpl_core DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reference_input_first(pins[0]),
    .reference_input_second(pins[1]), .feedback_clock_input(pins[2]),
    .tuning_word(tuning_word), .loop_tick(loop_tick));
  dpl_clk_src u_src (
    .pclk(pclk), .presetn(presetn), .req(req), .line(line),
    .toggles(toggles), .busy(busy), .pins(pins));

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic kick(logic [1:0] l, logic [7:0] t);
    line <= l;
    toggles <= t;
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
  endtask

  task automatic burst(logic [1:0] l, logic [7:0] t);
    kick(l, t);
    @(posedge pclk);
    while (busy) @(posedge pclk);
  endtask

  task automatic setup(logic [31:0] c, logic [15:0] dv);
    burst(2'h0, 8'h00);
    apb(1'b1, `DPL_OFF_REF_DIV, {16'h0000, dv});
    apb(1'b1, `DPL_OFF_FB_DIV, {16'h0000, dv});
    apb(1'b1, `DPL_OFF_CTRL, c | 32'h0000_0020);
    repeat (4) @(posedge pclk);
  endtask

  task automatic wrchk(logic [7:0] a, logic [31:0] d, logic [31:0] e);
    apb(1'b1, a, d);
    check("write error", rerr, a >= 8'h1C);
    apb(1'b0, a, 32'h0000_0000);
    check("read back", rdata, e);
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      setup({24'h00_0000, rows[i].ctrl}, rows[i].dv);
      burst(rows[i].ln, {4'h0, rows[i].nt});
      repeat (8) @(posedge pclk);
      apb(1'b0, `DPL_OFF_STATUS, 32'h0000_0000);
      check("comparator", rdata[6:4], rows[i].st);
      // Same comparison also
    end
    // Shadow divider waits for apply
    setup(32'h0000_0000, 16'h0000);
    apb(1'b1, `DPL_OFF_REF_DIV, 32'h0000_0007);
    apb(1'b0, `DPL_OFF_STATUS, 32'h0000_0000);
    check("pending", rdata[1], 1'b1);
    burst(2'h0, 8'h01);
    repeat (8) @(posedge pclk);
    apb(1'b0, `DPL_OFF_STATUS, 32'h0000_0000);
    check("old ratio", rdata[6:4], 3'h2);
    // Slow loop so the samples stay unconsumed; rate chosen
    setup(32'h0000_0C00, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      kick(k == 2 ? 2'h2 : 2'h0, 8'h02);
      // Odd width so a coarse result must drop its low bits
      repeat (k == 1 ? 400 : 19) @(posedge pclk);
      burst(k == 2 ? 2'h0 : 2'h2, 8'h02);
      repeat (8) @(posedge pclk);
      apb(1'b0, `DPL_OFF_STATUS, 32'h0000_0000);
      check("coarse used", rdata[0], k == 1);
      check("sample new", rdata[8], 1'b1);
      apb(1'b0, `DPL_OFF_PHASE, 32'h0000_0000);
      n = k == 0 ? 20 : (k == 1 ? 400 : -20);
      check("phase", $signed(rdata) - n inside {[-4:4]}, 1'b1);
      if (k == 1)
        check("coarse step", rdata[1:0], 2'h0);
    end
    while (loop_tick !== 1'b1) @(negedge pclk);
    repeat (200) @(posedge pclk);
    check("tune moved", tuning_word != 32'h0000_0000, 1'b1);
    apb(1'b0, `DPL_OFF_STATUS, 32'h0000_0000);
    check("sample taken", rdata[8], 1'b0);
    // Loop rate: below-range exponent clamps to 5, a 32-cycle period
    for (int k = 0; k < 3; k++) begin
      n = k == 0 ? 3 : (k == 1 ? 6 : 10);
      apb(1'b1, `DPL_OFF_CTRL, 32'h0000_0020 | (n << 8));
      @(negedge pclk);
      while (loop_tick !== 1'b1) @(negedge pclk);
      @(negedge pclk);
      n = 1;
      while (loop_tick !== 1'b1 && n < 2000) begin
        @(negedge pclk);
        n++;
      end
      check("loop period", n, k == 0 ? 32 : (k == 1 ? 64 : 1024));
      // Power-of-two periods above also
      @(posedge pclk);
    end
    // Second reset mid-run
    presetn <= 1'b0;
    @(posedge pclk);
    check("tune reset", tuning_word, 32'h0000_0000);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `DPL_OFF_CTRL, 32'h0000_0000);
    check("ctrl reset", rdata, 32'h0000_0500);
    apb(1'b0, `DPL_OFF_GAIN, 32'h0000_0000);
    check("gain reset", rdata, 32'h0000_0284);
    wrchk(`DPL_OFF_CTRL, 32'h0000_1F3F, 32'h0000_101F);
    wrchk(`DPL_OFF_REF_DIV, 32'hFFFF_FFFF, 32'h0000_FFFF);
    wrchk(`DPL_OFF_FB_DIV, 32'h1234_5678, 32'h0000_5678);
    wrchk(`DPL_OFF_GAIN, 32'hFFFF_FFFF, 32'h0000_0FFF);
    wrchk(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    test_done();
  end
endmodule // tb
